// file: inc/lss_pkg.sv
// Shared constants for the banked local scratchpad store.
// Assumes one compute unit clock and lanes that issue quarter-wavefront slots.
package lss_pkg;
  localparam int LSS_CAP_BYTES  = 32768;  // Capacity per compute unit
  localparam int LSS_ADDR_W     = 15;     // Byte address width over the capacity
  localparam int LSS_WORD_W     = 32;     // Bank width in bits
  localparam int LSS_BYTES      = 4;      // Bank width in bytes
  localparam int LSS_BANK_LSB   = 2;      // Lowest bank-select address bit
  localparam int LSS_BANKS_BIG  = 32;     // Large configuration, bits 6:2
  localparam int LSS_BANKS_SML  = 16;     // Small configuration, bits 5:2
  localparam int LSS_SLOT_LANES = 16;     // Lanes per quarter-wavefront slot
  localparam int LSS_WIN_SLOTS  = 2;      // Slots compared together
  localparam int LSS_PCT_SCALE  = 100;    // Percent scale of the stall counter
  localparam int LSS_PCT_W      = 7;      // Width of the percent value

  // Access size codes
  localparam logic [1:0] LSS_SZ_BYTE = 2'h0;
  localparam logic [1:0] LSS_SZ_HALF = 2'h1;
  localparam logic [1:0] LSS_SZ_WORD = 2'h2;

  // Byte enables per size
  localparam logic [3:0] LSS_BE_BYTE = 4'h1;
  localparam logic [3:0] LSS_BE_HALF = 4'h3;
  localparam logic [3:0] LSS_BE_WORD = 4'hf;
  localparam logic [31:0] LSS_MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] LSS_MASK_HALF = 32'h0000_ffff;

  // Window state, one-hot
  typedef enum logic [2:0] {
    LSS_ST_FIRST  = 3'h1,
    LSS_ST_SECOND = 3'h2,
    LSS_ST_SERVE  = 3'h4
  } lss_state_t;
endpackage : lss_pkg

// file: verilog/lss_bank.sv
// One four-byte-wide scratchpad bank with byte write enables.
// Assumes the caller drives at most one access per cycle; read is combinational.
`timescale 1ns/1ps
`default_nettype none
module lss_bank
  import lss_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int IDX_W = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  ce,
  input  wire logic                  en,
  input  wire logic                  we,
  input  wire logic [IDX_W-1:0]      idx,
  input  wire logic [LSS_BYTES-1:0]  be,
  input  wire logic [LSS_WORD_W-1:0] wdata,
  output logic      [LSS_WORD_W-1:0] rdata
);
  // plain storage, no eviction
  // Each byte lane owns its array, so no two processes write one memory
  for (genvar k = 0; k < LSS_BYTES; k++) begin : g_byte
    logic [7:0] mem_q [DEPTH];

    // Contents stay until overwritten; nothing evicts or clears them
    assign rdata[k*8 +: 8] = mem_q[idx];

    always_ff @(posedge mclk) begin
      if (ce && en && we && be[k]) begin
        mem_q[idx] <= wdata[k*8 +: 8];
      end
    end
  end
endmodule : lss_bank
`default_nettype wire

// file: verilog/lss_scratchpad.sv
// Banked local scratchpad store of one compute unit, with conflict stall counter.
// Assumes lanes present quarter-wavefront slots and hold them while ready is low.
//
// Behaviour
// - Each compute unit owns 32 KB scratchpad.
// - Large: 32 banks, address bits 6:2.
// - Small: 16 banks, address bits 5:2.
// - One access per bank every cycle.
// - Same-bank different addresses served on consecutive cycles.
// - Conflicting wavefront stalls, replays only unserved lanes.
// - Busiest bank sets latency; 32 lanes take 32.
// - Identical address reads broadcast, no conflict.
// - Conflicts judged over two-slot, 32-lane window.
// - Two four-byte requests per stream processor.
// - Byte and halfword reads use full slot.
// - One operation starts two four-byte loads.
// - Counter gives conflict stall percent of busy.
// - No host path into the scratchpad.
// - Contents kept until overwritten or group ends; wg_start here clears only the counters, not the banks.
`timescale 1ns/1ps
`default_nettype none
module lss_scratchpad
  import lss_pkg::*;
#(
  parameter int NBANKS = LSS_BANKS_BIG,
  parameter int CNT_W  = 32,
  parameter int SLOT   = LSS_SLOT_LANES
) (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         ce,
  input  wire logic                         req_valid,
  input  wire logic                         req_last,
  input  wire logic [SLOT-1:0]              req_lane_en,
  input  wire logic [SLOT-1:0]              req_we,
  input  wire logic [SLOT*2-1:0]            req_size,
  input  wire logic [SLOT*LSS_ADDR_W-1:0]   req_addr,
  input  wire logic [SLOT*LSS_WORD_W-1:0]   req_wdata,
  output logic                              req_ready,
  output logic [2*SLOT-1:0]                 rsp_mask_q,
  output logic [2*SLOT*LSS_WORD_W-1:0]      rsp_data_q,
  output logic                              rsp_done_q,
  input  wire logic                         gpu_busy,
  input  wire logic                         wg_start,
  output logic [CNT_W-1:0]                  busy_cnt_q,
  output logic [CNT_W-1:0]                  stall_cnt_q,
  output logic [LSS_PCT_W-1:0]              conflict_stall_percent_counter
);
  localparam int WIN   = SLOT * LSS_WIN_SLOTS;
  localparam int BW    = $clog2(NBANKS);
  localparam int DEPTH = LSS_CAP_BYTES / (NBANKS * LSS_BYTES);
  localparam int IDX_W = LSS_ADDR_W - LSS_BANK_LSB - BW;
  localparam int WA_W  = LSS_ADDR_W - LSS_BANK_LSB;

  lss_state_t            st_q, st_d;
  logic [WIN-1:0]        pend_q, we_q, served;
  logic [LSS_ADDR_W-1:0] addr_q  [WIN];
  logic [LSS_WORD_W-1:0] wdata_q [WIN];
  logic [1:0]            size_q  [WIN];
  logic [BW-1:0]         bank    [WIN];
  logic [IDX_W-1:0]      widx    [WIN];
  logic [3:0]            lbe     [WIN];
  logic [LSS_WORD_W-1:0] lwd     [WIN];
  logic [LSS_WORD_W-1:0] lrd     [WIN];
  logic [LSS_WORD_W-1:0] rd      [NBANKS];
  logic [LSS_PCT_W-1:0]  pct_q;
  logic                  serve, take, hi_half, left_over;

  // Window control
  assign serve     = (st_q == LSS_ST_SERVE);
  // A frozen block must not take a slot it cannot capture
  assign req_ready = ce && !serve;
  assign take      = req_valid && req_ready;
  assign hi_half   = (st_q == LSS_ST_SECOND);
  // busiest bank keeps the window serving
  assign left_over = |(pend_q & ~served);

  // two slots, or one slot marked last, fill one window, then serve
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      LSS_ST_FIRST:  if (take) st_d = req_last ? LSS_ST_SERVE : LSS_ST_SECOND;
      LSS_ST_SECOND: if (take) st_d = LSS_ST_SERVE;
      LSS_ST_SERVE:  if (!left_over) st_d = LSS_ST_FIRST;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= LSS_ST_FIRST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Per-lane capture, decode, arbitration and response
  for (genvar l = 0; l < WIN; l++) begin : g_lane
    localparam int S = l % SLOT;
    localparam logic HI = (l >= SLOT);
    logic [4:0]       sh;
    logic [WIN-1:0]   ldr_oh;
    logic [WA_W-1:0]  ldr_wa;
    logic             ldr_we;

    assign bank[l] = addr_q[l][LSS_BANK_LSB +: BW];
    assign widx[l] = addr_q[l][LSS_BANK_LSB+BW +: IDX_W];
    assign sh      = {addr_q[l][1:0], 3'h0};
    // narrow accesses still hold the whole bank slot
    assign lbe[l]  = (size_q[l] == LSS_SZ_BYTE) ? (LSS_BE_BYTE << addr_q[l][1:0]) :
                     (size_q[l] == LSS_SZ_HALF) ? (LSS_BE_HALF << addr_q[l][1:0]) :
                     LSS_BE_WORD;
    assign lwd[l]  = wdata_q[l] << sh;
    assign lrd[l]  = (size_q[l] == LSS_SZ_BYTE) ? ((rd[bank[l]] >> sh) & LSS_MASK_BYTE) :
                     (size_q[l] == LSS_SZ_HALF) ? ((rd[bank[l]] >> sh) & LSS_MASK_HALF) :
                     rd[bank[l]];

    // lowest pending lane of the same bank leads this cycle
    always_comb begin
      ldr_oh = '0;
      ldr_wa = addr_q[l][LSS_ADDR_W-1:LSS_BANK_LSB];
      ldr_we = we_q[l];
      for (int j = WIN - 1; j >= 0; j--) begin
        if (pend_q[j] && (addr_q[j][LSS_BANK_LSB +: BW] == bank[l])) begin
          ldr_oh = WIN'(1) << j;
          ldr_wa = addr_q[j][LSS_ADDR_W-1:LSS_BANK_LSB];
          ldr_we = we_q[j];
        end
      end
    end

    // same word as the leader rides along, no conflict
    assign served[l] = serve && pend_q[l] && (|ldr_oh) &&
                       (ldr_wa == addr_q[l][LSS_ADDR_W-1:LSS_BANK_LSB]) &&
                       (ldr_we == we_q[l]);

    // slot lanes fill the low, then the high, half
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        pend_q[l]  <= 1'b0;
        we_q[l]    <= 1'b0;
        addr_q[l]  <= '0;
        wdata_q[l] <= '0;
        size_q[l]  <= LSS_SZ_WORD;
      end else if (ce && take && (hi_half == HI)) begin
        pend_q[l]  <= req_lane_en[S];
        we_q[l]    <= req_we[S];
        addr_q[l]  <= req_addr[S*LSS_ADDR_W +: LSS_ADDR_W];
        wdata_q[l] <= req_wdata[S*LSS_WORD_W +: LSS_WORD_W];
        // requests are at most four bytes; larger codes act as words
        size_q[l]  <= (req_size[S*2 +: 2] > LSS_SZ_WORD) ? LSS_SZ_WORD : req_size[S*2 +: 2];
      end else if (ce && take && HI) begin
        pend_q[l]  <= 1'b0;
      end else if (ce && served[l]) begin
        // only unserved lanes replay next cycle
        pend_q[l]  <= 1'b0;
      end
    end

    // read data lands one cycle after service
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        rsp_mask_q[l]                       <= 1'b0;
        rsp_data_q[l*LSS_WORD_W +: LSS_WORD_W] <= '0;
      end else if (ce) begin
        rsp_mask_q[l] <= served[l];
        if (served[l] && !we_q[l]) begin
          rsp_data_q[l*LSS_WORD_W +: LSS_WORD_W] <= lrd[l];
        end
      end
    end
  end

  // Per-bank port selection
  for (genvar b = 0; b < NBANKS; b++) begin : g_bank
    logic             b_en, b_we;
    logic [IDX_W-1:0] b_idx;
    logic [3:0]       b_be;
    logic [LSS_WORD_W-1:0] b_wd;

    // at most one word per bank per cycle
    always_comb begin
      b_en  = 1'b0;
      b_we  = 1'b0;
      b_idx = '0;
      b_be  = '0;
      b_wd  = '0;
      for (int l = 0; l < WIN; l++) begin
        // later, higher lane overrides the write
        if (served[l] && (bank[l] == BW'(b))) begin
          b_en  = 1'b1;
          b_we  = we_q[l];
          b_idx = widx[l];
          b_be  = lbe[l];
          b_wd  = lwd[l];
        end
      end
    end

    // banks are reached from lane requests only
    lss_bank #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_bank (
      .mclk  (mclk),
      .ce    (ce),
      .en    (b_en),
      .we    (b_we),
      .idx   (b_idx),
      .be    (b_be),
      .wdata (b_wd),
      .rdata (rd[b])
    );
  end

  // busy time, conflict stall time and their percentage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_q  <= '0;
      stall_cnt_q <= '0;
      pct_q       <= '0;
      rsp_done_q  <= 1'b0;
    end else if (ce) begin
      rsp_done_q <= serve && !left_over;
      if (wg_start) begin
        busy_cnt_q  <= '0;
        stall_cnt_q <= '0;
        pct_q       <= '0;
      end else begin
        busy_cnt_q  <= busy_cnt_q + CNT_W'(gpu_busy);
        stall_cnt_q <= stall_cnt_q + CNT_W'(gpu_busy && serve && left_over);
        pct_q       <= (busy_cnt_q == '0) ? '0 :
                       LSS_PCT_W'((stall_cnt_q * CNT_W'(LSS_PCT_SCALE)) / busy_cnt_q);
      end
    end
  end
  assign conflict_stall_percent_counter = pct_q;

  // Service cycles of the current window, for the latency check
  logic [7:0] svc_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      svc_q <= '0;
    end else if (ce) begin
      svc_q <= serve ? svc_q + 8'h1 : 8'h0;
    end
  end

  // no slot is taken while a window serves
  a_ready_low_serve: assert property (@(posedge mclk) disable iff (!rstn)
    serve |-> !req_ready) else $error("ready high while serving");
  a_serve_progress: assert property (@(posedge mclk) disable iff (!rstn)
    (serve && pend_q != '0) |-> served != '0) else $error("no lane served");
  // served lanes drop out of the replay
  a_served_pending: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && serve) |=> (pend_q & $past(served)) == '0) else $error("served lane still pending");
  // window ends after its last service
  a_window_done: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && serve && !left_over) |=> (st_q == LSS_ST_FIRST) && rsp_done_q)
    else $error("window did not close");
  // response mask mirrors served lanes one cycle on
  a_rsp_follows: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> rsp_mask_q == $past(served)) else $error("response mask mismatch");
  // a window never needs more cycles than lanes
  a_latency_bound: assert property (@(posedge mclk) disable iff (!rstn)
    serve |-> svc_q < 8'(WIN)) else $error("window too slow");
  a_pct_zero: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && stall_cnt_q == '0) |=> pct_q == '0) else $error("percent nonzero");
  a_broadcast: assert property (@(posedge mclk) disable iff (!rstn)
    (serve && pend_q[0] && pend_q[1] && !we_q[0] && !we_q[1] && addr_q[0] == addr_q[1])
    |-> served[1]) else $error("broadcast lost");

  c_one_cycle: cover property (@(posedge mclk) disable iff (!rstn)
    serve && !left_over && svc_q == 8'h0);
  c_full_conflict: cover property (@(posedge mclk) disable iff (!rstn)
    serve && svc_q == 8'(WIN - 1));
  c_stall_seen: cover property (@(posedge mclk) disable iff (!rstn)
    pct_q != '0);
endmodule : lss_scratchpad
`default_nettype wire

// file: tb/lss_lanes.sv
// Lane-side model that presents quarter-wavefront slots to the scratchpad.
// Assumes the bench calls its tasks at a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module lss_lanes
  import lss_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         req_ready,
  output logic              req_valid,
  output logic              req_last,
  output logic [15:0]       req_lane_en,
  output logic [15:0]       req_we,
  output logic [31:0]       req_size,
  output logic [239:0]      req_addr,
  output logic [511:0]      req_wdata
);
  // Idle values at time zero
  initial begin
    req_valid = 1'b0;
    req_last = 1'b0;
    req_lane_en = 16'h0;
    req_we = 16'h0;
    req_size = 32'h0;
    req_addr = 240'h0;
    req_wdata = 512'h0;
  end

  task automatic send(input logic [15:0] we, input logic [31:0] sz, input logic [239:0] ad,
                      input logic [511:0] wd, input logic last, output logic ok);
    int n;
    req_valid <= 1'b1;
    req_last <= last;
    req_lane_en <= 16'hffff;
    req_we <= we;
    req_size <= sz;
    req_addr <= ad;
    req_wdata <= wd;
    ok = 1'b0;
    for (n = 0; n < 200 && ok !== 1'b1; n++) begin
      @(negedge mclk);
      ok = req_ready;
    end
    @(posedge mclk);
  endtask : send

  // Address and data lines show the inverse of their last value; valid and last drop low
  task automatic idle();
    req_valid <= 1'b0;
    req_last <= 1'b0;
    req_addr <= ~req_addr;
    req_wdata <= ~req_wdata;
  endtask : idle
endmodule : lss_lanes
`default_nettype wire

// file: tb/lss_scratchpad_bench.sv
// Self-checking bench for the banked scratchpad store, large configuration.
// Assumes the lane model holds each slot until ready and ce stays high outside t_hold.
`timescale 1ns/1ps
`default_nettype none
module lss_scratchpad_bench;
  import lss_pkg::*;
  logic mclk, rstn, ce, gpu_busy, wg_start, req_ready, req_valid, req_last, rsp_done_q;
  logic [15:0]  req_lane_en, req_we;
  logic [31:0]  req_size, rsp_mask_q, busy_cnt_q, stall_cnt_q;
  logic [239:0] req_addr;
  logic [511:0] req_wdata;
  logic [1023:0] rsp_data_q;
  logic [6:0]   pct;
  logic [31:0]  rd [32];
  logic [31:0]  msk;
  int n, n_errors, num_checks;

  lss_scratchpad lss_scratchpad_i (.mclk(mclk), .rstn(rstn), .ce(ce),
    .req_valid(req_valid), .req_last(req_last), .req_lane_en(req_lane_en),
    .req_we(req_we), .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_mask_q(rsp_mask_q), .rsp_data_q(rsp_data_q),
    .rsp_done_q(rsp_done_q), .gpu_busy(gpu_busy), .wg_start(wg_start),
    .busy_cnt_q(busy_cnt_q), .stall_cnt_q(stall_cnt_q),
    .conflict_stall_percent_counter(pct));
  lss_lanes lss_lanes_i (.mclk(mclk), .req_ready(req_ready), .req_valid(req_valid),
    .req_last(req_last), .req_lane_en(req_lane_en), .req_we(req_we),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata));

  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One 32-lane window, or 16 lanes with one set; n counts edges from the last take to done
  task automatic win(input logic wr, input logic [1:0] sz, input int base, input int stride,
                     input int dbase, input logic one = 1'b0);
    logic [1:0][239:0] ad;
    logic [1:0][511:0] wd;
    logic ok;
    for (int l = 0; l < 32; l++) begin
      ad[l/16][(l%16)*15+:15] = 15'(base + l*stride);
      wd[l/16][(l%16)*32+:32] = 32'(dbase + l);
    end
    @(posedge mclk);
    lss_lanes_i.send({16{wr}}, {16{sz}}, ad[0], wd[0], one, ok);
    chk(ok, 1'b1);
    if (!one) begin
      lss_lanes_i.send({16{wr}}, {16{sz}}, ad[1], wd[1], 1'b0, ok);
      chk(ok, 1'b1);
    end
    lss_lanes_i.idle();
    msk = 32'h0;
    for (n = 1; n <= 100; n++) begin
      @(posedge mclk);
      #1;
      msk |= rsp_mask_q;
      if (rsp_done_q === 1'b1) break;
    end
    if (n > 100) begin
      chk(1'b0, 1'b1);
      close_out();
    end
    for (int l = 0; l < 32; l++) rd[l] = rsp_data_q[l*32+:32];
    chk(msk, one ? 32'h0000_ffff : 32'hffff_ffff);
  endtask : win

  task automatic clear_counts();
    @(posedge mclk);
    wg_start <= 1'b1;
    @(posedge mclk);
    wg_start <= 1'b0;
  endtask : clear_counts

  // Distinct banks: single service cycle, data kept for a later read
  task automatic t_free();
    clear_counts();
    win(1'b1, LSS_SZ_WORD, 0, 4, 32'ha000);
    chk(n, 1);
    // read only after the write window completed
    win(1'b0, LSS_SZ_WORD, 0, 4, 0);
    chk(n, 1);
    for (int l = 0; l < 32; l++) chk(rd[l], 32'ha000 + l);
    repeat (3) @(posedge mclk);
    #1;
    chk(stall_cnt_q, 0);
    chk(pct, 0);
    $display("test t_free done");
  endtask : t_free

  // All lanes in bank 0 at distinct words: serialised, counted as stalls
  task automatic t_conf();
    clear_counts();
    win(1'b1, LSS_SZ_WORD, 0, 128, 32'hb000);
    chk(n, 32);
    win(1'b0, LSS_SZ_WORD, 0, 128, 0);
    chk(n, 32);
    for (int l = 0; l < 32; l++) chk(rd[l], 32'hb000 + l);
    repeat (3) @(posedge mclk);
    #1;
    chk(stall_cnt_q, 62);
    chk(pct !== 7'h0, 1'b1);
    $display("test t_conf done");
  endtask : t_conf

  // One word written by all lanes, then read by all lanes
  task automatic t_bcast();
    win(1'b1, LSS_SZ_WORD, 32'h40, 0, 32'hc000);
    chk(n, 1);
    win(1'b0, LSS_SZ_WORD, 32'h40, 0, 0);
    chk(n, 1);
    for (int l = 0; l < 32; l++) chk(rd[l], 32'hc000 + 31);
    $display("test t_bcast done");
  endtask : t_bcast

  // Byte reads at offset one return the zero-extended byte
  task automatic t_byte();
    win(1'b1, LSS_SZ_WORD, 32'h400, 4, 32'h1234_5600);
    win(1'b0, LSS_SZ_BYTE, 32'h401, 4, 0);
    chk(n, 1);
    for (int l = 0; l < 32; l++) chk(rd[l], 32'h56);
    $display("test t_byte done");
  endtask : t_byte

  // A single slot marked last forms a 16-lane window; other lanes keep old data
  task automatic t_last();
    win(1'b0, LSS_SZ_WORD, 32'h400, 4, 0, 1'b1);
    chk(n, 1);
    for (int l = 0; l < 16; l++) chk(rd[l], 32'h1234_5600 + l);
    chk(rd[16], 32'h56);
    $display("test t_last done");
  endtask : t_last

  // Clock enable low: ready drops and the counters hold, then run on
  task automatic t_hold();
    logic [31:0] held;
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    #1;
    held = busy_cnt_q;
    chk(req_ready, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk(busy_cnt_q, held);
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    #1;
    chk(busy_cnt_q, held + 32'h1);
    $display("test t_hold done");
  endtask : t_hold

  // Main sequence: 12-cycle reset, then the scenarios
  initial begin
    n_errors = 0;
    num_checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    gpu_busy = 1'b0;
    wg_start = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    gpu_busy <= 1'b1;
    t_free();
    t_conf();
    t_bcast();
    t_byte();
    t_last();
    t_hold();
    close_out();
  end
endmodule : lss_scratchpad_bench
`default_nettype wire
